// ### inc/oaple_pkg.sv
package oaple_pkg;
   localparam int WORD_W = 16;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 4;
   localparam int PTR_N = 3;
   localparam int PTR_SEL_W = 2;
   localparam int PHASE_W = 2;
   // opcode patterns
   localparam logic [7:0] OP_OR_LIT = 8'h09;
   localparam logic [5:0] OP_OR_FILE = 6'h04;
   localparam logic [9:0] OP_PTR_W1 = 10'h3b8;
   localparam logic [7:0] OP_PTR_W2 = 8'hf0;
   // phase codes Q1..Q4
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   // access bank: low part is at bank 0, high part at bank f
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] INDEX_MAX = 8'h5f;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam int NEG_BIT = 7;
   localparam int IDX_PTR = 2;
   typedef enum logic [1:0] {OAPLE_IDLE, OAPLE_PTR_LOW} oaple_state_t;
endpackage : oaple_pkg

// ### src/oaple_core.sv
`timescale 1ns/1ps
`default_nettype none
module oaple_core
   import oaple_pkg::*;
#(
   parameter int PTRS = oaple_pkg::PTR_N
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [oaple_pkg::PHASE_W-1:0] phase,
   input wire logic [oaple_pkg::WORD_W-1:0] instr,
   input wire logic instr_valid,
   input wire logic ext_set_en,
   input wire logic [oaple_pkg::BANK_W-1:0] bank_select_reg,
   input wire logic [oaple_pkg::DATA_W-1:0] file_rdata,
   output logic [oaple_pkg::ADDR_W-1:0] file_addr,
   output logic [oaple_pkg::DATA_W-1:0] file_wdata,
   output logic file_we,
   output logic [oaple_pkg::DATA_W-1:0] acc,
   output logic flag_neg,
   output logic flag_zero,
   output logic [oaple_pkg::ADDR_W-1:0] indirect_pointer [PTRS],
   output logic busy
);
   import oaple_pkg::*;

   // indexed mode reads pointer IDX_PTR, so fewer pointers cannot serve it
   if (PTRS < IDX_PTR + 1 || PTRS > (1 << PTR_SEL_W)) begin : g_bad_ptrs
      $error("pointer count out of range");
   end

   oaple_state_t state;
   logic [PTR_SEL_W-1:0] ptr_sel;
   logic is_or_lit, is_or_file, is_ptr1, is_ptr2, q4;
   logic dest_file, access_bit, indexed;
   logic [7:0] faddr;
   logic [DATA_W-1:0] result;
   logic [ADDR_W-1:0] next_addr;

   // updates land on the Q4 edge, except file_wdata, captured every valid file-OR cycle; a flushed slot changes nothing
   assign q4 = (phase == PH_Q4) && instr_valid;
   assign is_or_lit = (state == OAPLE_IDLE) && (instr[15:8] == OP_OR_LIT);
   assign is_or_file = (state == OAPLE_IDLE) && (instr[15:10] == OP_OR_FILE);
   assign is_ptr1 = (state == OAPLE_IDLE) && (instr[15:6] == OP_PTR_W1)
      && (32'(instr[5:4]) < PTRS);
   assign is_ptr2 = (state == OAPLE_PTR_LOW) && (instr[15:8] == OP_PTR_W2);
   assign dest_file = instr[9];
   assign access_bit = instr[8];
   assign faddr = instr[7:0];
   assign indexed = !access_bit && ext_set_en && (faddr <= INDEX_MAX);

   // the indexed sum wraps within the 12-bit data space
   // access bank, banked, indexed offset from pointer 2
   always_comb begin
      if (indexed) begin
         next_addr = indirect_pointer[IDX_PTR] + {4'h0, faddr};
      end else if (access_bit) begin
         next_addr = {bank_select_reg, faddr};
      end else if (faddr < ACCESS_SPLIT) begin
         next_addr = {ACCESS_LO_BANK, faddr};
      end else begin
         next_addr = {ACCESS_HI_BANK, faddr};
      end
   end
   assign file_addr = next_addr;

   // the literal sits in the same low byte as the file address
   assign result = is_or_lit ? (acc | faddr) : (acc | file_rdata);

   // write data is captured every file-OR cycle, so the Q4 write needs no
   // extra stage; this relies on file_rdata holding steady from Q3 on
   // file write-back when destination set
   assign file_we = q4 && is_or_file && dest_file;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         file_wdata <= ACC_RESET;
      end else if (instr_valid && is_or_file) begin
         file_wdata <= result;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc <= ACC_RESET;
      end else if (q4 && (is_or_lit || (is_or_file && !dest_file))) begin
         acc <= result;
      end
   end

   // flags follow every OR, a written-back one too
   // status flags
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flag_neg <= 1'b0;
         flag_zero <= 1'b0;
      end else if (q4 && (is_or_lit || is_or_file)) begin
         flag_neg <= result[NEG_BIT];
         flag_zero <= (result == ACC_RESET);
      end
   end

   // a second word that is not the low-byte word drops the load;
   // the high nibble written in the first cycle then stays
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= OAPLE_IDLE;
         ptr_sel <= '0;
      end else if (q4) begin
         case (state)
            OAPLE_IDLE: begin
               if (is_ptr1) begin
                  state <= OAPLE_PTR_LOW;
                  ptr_sel <= instr[5:4];
               end
            end
            OAPLE_PTR_LOW: state <= OAPLE_IDLE;
            default: state <= OAPLE_IDLE;
         endcase
      end
   end
   assign busy = (state == OAPLE_PTR_LOW);

   // one register per pointer; selects past PTRS are refused at decode
   for (genvar g = 0; g < PTRS; g++) begin : g_ptr
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            indirect_pointer[g] <= PTR_RESET;
         end else if (q4 && is_ptr1 && 32'(instr[5:4]) == g) begin
            indirect_pointer[g][11:8] <= instr[3:0];
         end else if (q4 && is_ptr2 && 32'(ptr_sel) == g) begin
            indirect_pointer[g][7:0] <= instr[7:0];
         end
      end
   end

   sequence ptr_first_s;
      q4 && is_ptr1;
   endsequence
   sequence ptr_second_s;
      busy && q4 && is_ptr2;
   endsequence
   sequence ptr_abort_s;
      busy && q4 && !is_ptr2;
   endsequence

   lit_or_acc_a: assert property (@(posedge clk_sys) disable iff (rst)
      q4 && is_or_lit |=> acc == ($past(acc) | $past(instr[7:0])))
      else $error("literal or wrong");
   file_or_acc_a: assert property (@(posedge clk_sys) disable iff (rst)
      q4 && is_or_file && !dest_file |=>
      acc == ($past(acc) | $past(file_rdata)))
      else $error("file or to acc wrong");
   access_bank_a: assert property (@(posedge clk_sys) disable iff (rst)
      is_or_file && !access_bit && !ext_set_en |->
      file_addr[11:8] == (faddr < ACCESS_SPLIT ? ACCESS_LO_BANK :
      ACCESS_HI_BANK))
      else $error("access bank address wrong");
   banked_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
      is_or_file && access_bit |-> file_addr == {bank_select_reg, faddr})
      else $error("banked address wrong");
   indexed_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
      is_or_file && indexed |->
      file_addr == indirect_pointer[IDX_PTR] + {4'h0, faddr})
      else $error("indexed address wrong");
   ptr_two_word_a: assert property (@(posedge clk_sys) disable iff (rst)
      ptr_first_s |=> busy)
      else $error("pointer load not two words");
   ptr_high_a: assert property (@(posedge clk_sys) disable iff (rst)
      ptr_first_s |=> indirect_pointer[$past(instr[5:4])][11:8] ==
      $past(instr[3:0]))
      else $error("pointer high wrong");
   ptr_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      ptr_second_s |=> !busy && indirect_pointer[$past(ptr_sel)][7:0] ==
      $past(instr[7:0]))
      else $error("pointer low wrong");
   file_dest_a: assert property (@(posedge clk_sys) disable iff (rst)
      q4 && is_or_file && dest_file |-> file_we ##1 $stable(acc))
      else $error("file destination wrong");
   index_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      is_or_file && !access_bit && ext_set_en && faddr > INDEX_MAX |->
      file_addr == {ACCESS_HI_BANK, faddr})
      else $error("indexed gate wrong");
   flags_a: assert property (@(posedge clk_sys) disable iff (rst)
      q4 && (is_or_lit || is_or_file) |=>
      flag_zero == ($past(result) == 8'h00) && flag_neg == $past(result[7]))
      else $error("flags wrong");

   // refusals, aborted loads and flushed slots leave state alone
   flush_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      !instr_valid |=> $stable(acc) && $stable(flag_neg) &&
      $stable(flag_zero))
      else $error("flushed slot changed state");
   ptr_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
      q4 && !busy && instr[15:6] == OP_PTR_W1 && 32'(instr[5:4]) >= PTRS
      |=> !busy)
      else $error("pointer select out of range accepted");
   ptr_abort_a: assert property (@(posedge clk_sys) disable iff (rst)
      ptr_abort_s |=> !busy && $stable(acc))
      else $error("aborted pointer load not dropped");
   file_wdata_a: assert property (@(posedge clk_sys) disable iff (rst)
      file_we |-> file_wdata == (acc | file_rdata))
      else $error("write-back data wrong");
endmodule : oaple_core
`default_nettype wire

// ### sim/oaple_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module oaple_mem_model
   import oaple_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [oaple_pkg::ADDR_W-1:0] file_addr,
   input wire logic [oaple_pkg::DATA_W-1:0] file_wdata,
   input wire logic file_we,
   output logic [oaple_pkg::DATA_W-1:0] file_rdata
);
   logic [DATA_W-1:0] mem [2**ADDR_W];
   // address-dependent fill so a wrong bank reads a different byte
   initial begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
         mem[i] = i[7:0] ^ {i[11:8], i[11:8]};
      end
   end
   assign file_rdata = mem[file_addr];
   always @(posedge clk_sys) begin
      if (file_we) begin
         mem[file_addr] <= file_wdata;
      end
   end
endmodule : oaple_mem_model
`default_nettype wire

// ### sim/or_and_pointer_load_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module or_and_pointer_load_exec_tb_top;
   import oaple_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic instr_valid = 1'b0;
   logic ext_set_en = 1'b0;
   logic file_we, flag_neg, flag_zero, busy;
   logic [PHASE_W-1:0] phase = 2'h0;
   logic [WORD_W-1:0] instr = 16'h0000;
   logic [BANK_W-1:0] bank_select_reg = 4'h5;
   logic [DATA_W-1:0] file_rdata, file_wdata, acc;
   logic [DATA_W-1:0] acc_exp = 8'h00;
   logic [ADDR_W-1:0] file_addr, seen_addr;
   logic [ADDR_W-1:0] ptr [PTR_N];
   logic [ADDR_W-1:0] ptr_exp [PTR_N] = '{default: 12'h000};
   int fail_count = 0;
   int checks_done = 0;
   always #10 clk_sys = ~clk_sys;
   oaple_core i_dut (.clk_sys(clk_sys), .rst(rst), .phase(phase),
      .instr(instr), .instr_valid(instr_valid), .ext_set_en(ext_set_en),
      .bank_select_reg(bank_select_reg), .file_rdata(file_rdata),
      .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
      .acc(acc), .flag_neg(flag_neg), .flag_zero(flag_zero),
      .indirect_pointer(ptr), .busy(busy));
   oaple_mem_model i_mem (.clk_sys(clk_sys), .file_addr(file_addr),
      .file_wdata(file_wdata), .file_we(file_we), .file_rdata(file_rdata));
   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]};
   endfunction : pat
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   // one Q1..Q4 group, entered and left at a falling edge
   task automatic run(input logic [WORD_W-1:0] w, input logic v = 1'b1);
      instr = w;
      instr_valid = v;
      for (int q = 0; q < 4; q++) begin
         phase = q[1:0];
         @(negedge clk_sys);
         if (q == 1) seen_addr = file_addr;
      end
   endtask : run
   task automatic chk_res(input logic [7:0] res);
      chk(acc, acc_exp);
      chk(flag_neg, res[7]);
      chk(flag_zero, res == 8'h00);
   endtask : chk_res
   task automatic lit(input logic [7:0] k);
      run({OP_OR_LIT, k});
      acc_exp = acc_exp | k;
      chk_res(acc_exp);
   endtask : lit
   task automatic fcase(input logic d, input logic a, input logic [7:0] f,
      input logic ext, input logic [11:0] addr);
      logic [7:0] res;
      ext_set_en = ext;
      res = acc_exp | pat(addr);
      run({OP_OR_FILE, d, a, f});
      chk(seen_addr, addr);
      if (d) begin
         chk(i_mem.mem[addr], res);
      end else begin
         chk(i_mem.mem[addr], pat(addr));
         acc_exp = res;
      end
      chk_res(res);
   endtask : fcase
   task automatic ptrload(input int s, input logic [11:0] v);
      run({OP_PTR_W1, s[1:0], v[11:8]});
      if (s < PTR_N) begin
         chk(busy, 1'b1);
         chk(ptr[s][11:8], v[11:8]);
      end else begin
         chk(busy, 1'b0);
      end
      run({OP_PTR_W2, v[7:0]});
      chk(busy, 1'b0);
      if (s < 3) ptr_exp[s] = v;
      for (int i = 0; i < PTR_N; i++) chk(ptr[i], ptr_exp[i]);
   endtask : ptrload
   // a second word that is not the low-byte word ends the load early
   task automatic ptr_abort(input logic [11:0] v);
      run({OP_PTR_W1, 2'h1, v[11:8]});
      run({OP_OR_LIT, v[7:0]});
      ptr_exp[1][11:8] = v[11:8];
      chk(busy, 1'b0);
      chk(acc, acc_exp);
      for (int i = 0; i < PTR_N; i++) chk(ptr[i], ptr_exp[i]);
   endtask : ptr_abort
   // a word with valid low is a flushed slot and must change nothing
   task automatic flushed();
      run({OP_OR_LIT, 8'hff}, 1'b0);
      chk(acc, acc_exp);
      chk(busy, 1'b0);
   endtask : flushed
   // reset in mid-run, with a pointer load pending, clears every register
   task automatic mid_reset();
      run({OP_PTR_W1, 2'h0, 4'h7});
      chk(busy, 1'b1);
      instr_valid = 1'b0;
      rst = 1'b1;
      @(negedge clk_sys);
      chk(acc, ACC_RESET);
      chk(flag_neg, 1'b0);
      chk(flag_zero, 1'b0);
      chk(busy, 1'b0);
      for (int i = 0; i < PTR_N; i++) chk(ptr[i], PTR_RESET);
      rst = 1'b0;
      @(negedge clk_sys);
      acc_exp = ACC_RESET;
      ptr_exp = '{default: PTR_RESET};
   endtask : mid_reset
   initial begin
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      lit(8'h00);
      // select 3 is refused, so the last load must leave all pointers
      for (int k = 0; k < 4; k++) ptrload(k, 12'(12'h3ab + 12'h111 * k));
      ptr_abort(12'h9e1);
      flushed();
      fcase(1'b0, 1'b0, 8'h10, 1'b0, 12'h010);
      fcase(1'b0, 1'b0, 8'h70, 1'b0, 12'hf70);
      fcase(1'b0, 1'b1, 8'h10, 1'b1, 12'h510);
      fcase(1'b0, 1'b0, 8'h10, 1'b1, 12'h5dd);
      fcase(1'b0, 1'b0, 8'h5f, 1'b1, 12'h62c);
      fcase(1'b0, 1'b0, 8'h60, 1'b1, 12'hf60);
      fcase(1'b1, 1'b1, 8'h20, 1'b0, 12'h520);
      mid_reset();
      lit(8'h35);
      results();
   end
   initial begin
      #100000;
      fail_count++;
      results();
   end
endmodule : or_and_pointer_load_exec_tb_top
`default_nettype wire
